// ===== pkg/sd_seq_regs.vh
`ifndef SD_SEQ_REGS_VH
`define SD_SEQ_REGS_VH

// Clock
`define SD_CLK_HZ          100000000
`define SD_CLK_NS          10

// Oscillator rates and periods in reference clocks (longest period rounds down)
`define SD_OSC_LOW_HZ      333000
`define SD_OSC_HIGH_HZ     500000
`define SD_OSC_LOW_CYC     (`SD_CLK_HZ / `SD_OSC_LOW_HZ)
`define SD_OSC_HIGH_CYC    (`SD_CLK_HZ / `SD_OSC_HIGH_HZ)
`define SD_OSC_W           9

// Dead time between complementary drives (least time rounds up)
`define SD_DEAD_NS         60
`define SD_DEAD_CYC        ((`SD_DEAD_NS + `SD_CLK_NS - 1) / `SD_CLK_NS)
`define SD_DEAD_W          4

// Momentary timing-pin discharge pulse
`define SD_DISCH_NS        1000
`define SD_DISCH_CYC       ((`SD_DISCH_NS + `SD_CLK_NS - 1) / `SD_CLK_NS)
`define SD_DISCH_W         8

// Power-good timeout in oscillator cycles
`define SD_PGOOD_CYCLES    32000
`define SD_PGOOD_W         15

// Synchronised input vector field positions
`define SD_IN_PD_N         0
`define SD_IN_FSEL         1
`define SD_IN_FORCE        2
`define SD_IN_STRAP_REF    3
`define SD_IN_STRAP_VL     4
`define SD_IN_LO_ON        5
`define SD_IN_HI_ON        6
`define SD_IN_LO_REG       7
`define SD_IN_HI_REG       8
`define SD_IN_BOOT         9
`define SD_IN_LO_LIM       10
`define SD_IN_LO_ZERO      11
`define SD_IN_LO_TRIP      12
`define SD_IN_LO_LIGHT     13
`define SD_IN_HI_LIM       14
`define SD_IN_HI_ZERO      15
`define SD_IN_HI_TRIP      16
`define SD_IN_HI_LIGHT     17
`define SD_IN_W            18
`define SD_IN_RESET        18'h00000

`endif

// ===== design/sd_rail_drive.v
`timescale 1ns/1ns
`include "sd_seq_regs.vh"

module sd_rail_drive (
  // Clock and reset
  input  wire ref_clk,
  input  wire arst_n,
  // Control, all on ref_clk
  input  wire enable,
  input  wire cycle_start,
  input  wire force_pwm,
  input  wire light_load,
  input  wire pwm_trip,
  input  wire cur_limit,
  input  wire zero_cross,
  // Drives
  output reg  high_side_drive,
  output reg  low_side_drive,
  output wire idle_skip
);

  localparam [4:0] ST_OFF  = 5'h01;
  localparam [4:0] ST_WHI  = 5'h02;
  localparam [4:0] ST_HIGH = 5'h04;
  localparam [4:0] ST_WLO  = 5'h08;
  localparam [4:0] ST_LOW  = 5'h10;
  localparam integer DEAD_LAST = `SD_DEAD_CYC - 1;
  localparam integer ONE       = 1;

  reg [4:0]              state;
  reg [4:0]              next_state;
  reg [`SD_DEAD_W-1:0]   dead_cnt;
  wire                   dead_done;

  // Light load may skip a pulse only outside forced PWM
  assign idle_skip = !force_pwm && light_load;                         // [R1]
  assign dead_done = (dead_cnt == DEAD_LAST[`SD_DEAD_W-1:0]);

  always @*
  begin
    next_state = state;
    case (state)
      ST_OFF:  if (enable && cycle_start && !idle_skip && !cur_limit) next_state = ST_WHI;
      ST_WHI:  if (!enable || cur_limit) next_state = ST_OFF;
               else if (dead_done) next_state = ST_HIGH;
      // Limit in either direction ends the on-time at once
      ST_HIGH: if (!enable || cur_limit || pwm_trip) next_state = ST_WLO;  // [R14]
      ST_WLO:  if (!enable) next_state = ST_OFF;
               else if (dead_done) next_state = ST_LOW;                  // [R18]
      // Low side holds until next cycle, or zero crossing when discontinuous
      ST_LOW:  if (!enable || (!force_pwm && zero_cross)) next_state = ST_OFF;   // [R16]
               else if (cycle_start && !idle_skip && !cur_limit) next_state = ST_WHI; // [R18]
               else if (cycle_start) next_state = ST_OFF;
      default: next_state = ST_OFF;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state           <= ST_OFF;
      dead_cnt        <= {`SD_DEAD_W{1'b0}};
      high_side_drive <= 1'b0;
      low_side_drive  <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        dead_cnt <= {`SD_DEAD_W{1'b0}};
      else
        dead_cnt <= dead_cnt + ONE[`SD_DEAD_W-1:0];
      // Complementary drives, never both on
      high_side_drive <= (next_state == ST_HIGH);                        // [R15]
      low_side_drive  <= (next_state == ST_LOW);                         // [R15]
    end
  end

endmodule

// ===== design/sd_sequencer.v
`timescale 1ns/1ns
`include "sd_seq_regs.vh"

// Contract
// R1: Skip low allows idle; high forces PWM
// R2: Oscillator 333kHz when select low, 500kHz high
// R3: Select falling edge starts new oscillator cycle
// R4: External clock stays within capture range limits
// R5: Power-down low forces full shutdown, overrides all
// R6: Strap at reference: independent enables per rail
// R7: Strap otherwise: low-rail pin is master enable
// R8: Strap high 3.3V first; ground 5V first
// R9: Second rail waits on timing-pin delay
// R10: Discharge continuous in standby, pulsed otherwise
// R11: Reset low until both rails regulate
// R12: Count 32000 oscillator cycles, then release reset
// R13: Strap at reference monitors only 3.3V rail
// R14: Current limit resets latch, drops high side
// R15: Low drive complements high with dead time
// R16: Discontinuous mode: low off at zero crossing
// R17: Above switchover: bypass on, linear regulator off
// R18: Dead time before low on, held until cycle
// R19: Enables low means both rails in standby
// R20: Comparator inputs synchronised before any use
// R21: Shutdown or standby clears power-good counter

module sd_sequencer (
  // Clock and power-on reset
  input  wire ref_clk,
  input  wire arst_n,
  // Control pins
  input  wire power_down_n,
  input  wire freq_select,
  input  wire force_pwm,
  input  wire low_rail_on,
  input  wire high_rail_on_or_delay,
  // Order-select strap, decoded to two levels
  input  wire order_select_strap_ref,
  input  wire order_select_strap_internal_rail,
  // Rail monitors
  input  wire low_rail_in_reg,
  input  wire high_rail_in_reg,
  input  wire high_rail_sense_low_above,
  // Low rail switching comparators
  input  wire low_cur_limit,
  input  wire low_zero_cross,
  input  wire low_pwm_trip,
  input  wire low_light_load,
  // High rail switching comparators
  input  wire high_cur_limit,
  input  wire high_zero_cross,
  input  wire high_pwm_trip,
  input  wire high_light_load,
  // Drives
  output wire low_high_side_drive,
  output wire low_low_side_drive,
  output wire high_high_side_drive,
  output wire high_low_side_drive,
  // Bias control
  output reg  bypass_switch_on,
  output reg  internal_rail_regulator_on,
  output reg  timing_discharge,
  // Status
  output reg  low_rail_enabled,
  output reg  high_rail_enabled,
  output reg  power_good,
  output reg  mode_shutdown,
  output reg  mode_standby,
  output reg  osc_cycle_start,
  output wire low_idle_active,
  output wire high_idle_active
);

  //////////////////////////////////////////////////////////////////////////////
  // Input synchroniser

  localparam [2:0] MD_SHUT  = 3'h1;
  localparam [2:0] MD_STBY  = 3'h2;
  localparam [2:0] MD_RUN   = 3'h4;
  localparam integer OSC_HIGH_LAST = `SD_OSC_HIGH_CYC - 1;
  localparam integer OSC_LOW_LAST  = `SD_OSC_LOW_CYC - 1;
  localparam integer DISCH_LOAD    = `SD_DISCH_CYC;
  localparam integer PGOOD_LAST    = `SD_PGOOD_CYCLES - 1;
  localparam integer ONE           = 1;

  wire [`SD_IN_W-1:0] pin_raw;
  reg  [`SD_IN_W-1:0] pin_meta;
  reg  [`SD_IN_W-1:0] pin_sync;

  assign pin_raw = {high_light_load, high_pwm_trip, high_zero_cross, high_cur_limit,
                    low_light_load, low_pwm_trip, low_zero_cross, low_cur_limit,
                    high_rail_sense_low_above, high_rail_in_reg, low_rail_in_reg,
                    high_rail_on_or_delay, low_rail_on,
                    order_select_strap_internal_rail, order_select_strap_ref,
                    force_pwm, freq_select, power_down_n};

  // Every pin passes two flops before use
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_meta <= `SD_IN_RESET;
      pin_sync <= `SD_IN_RESET;
    end
    else
    begin
      pin_meta <= pin_raw;                                               // [R20]
      pin_sync <= pin_meta;                                              // [R20]
    end
  end

  wire s_pd_n      = pin_sync[`SD_IN_PD_N];
  wire s_fsel      = pin_sync[`SD_IN_FSEL];
  wire s_force     = pin_sync[`SD_IN_FORCE];
  wire s_strap_ref = pin_sync[`SD_IN_STRAP_REF];
  wire s_strap_vl  = pin_sync[`SD_IN_STRAP_VL];
  wire s_lo_on     = pin_sync[`SD_IN_LO_ON];
  wire s_hi_on     = pin_sync[`SD_IN_HI_ON];
  wire s_lo_reg    = pin_sync[`SD_IN_LO_REG];
  wire s_hi_reg    = pin_sync[`SD_IN_HI_REG];
  wire s_boot      = pin_sync[`SD_IN_BOOT];

  //////////////////////////////////////////////////////////////////////////////
  // Oscillator

  reg  [`SD_OSC_W-1:0] osc_cnt;
  reg                  fsel_last;
  wire                 fsel_fall;
  wire [`SD_OSC_W-1:0] osc_last;

  // Held level picks the period; an external clock is followed edge by edge
  assign osc_last  = s_fsel ? OSC_HIGH_LAST[`SD_OSC_W-1:0]                 // [R2]
                            : OSC_LOW_LAST[`SD_OSC_W-1:0];                 // [R2]
  assign fsel_fall = fsel_last && !s_fsel;

  // Sync faster than the free period restarts before the count ends.
  // Slower sync still gets a free-running pulse at the selected rate.
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_cnt         <= {`SD_OSC_W{1'b0}};
      fsel_last       <= 1'b0;
      osc_cycle_start <= 1'b0;
    end
    else
    begin
      fsel_last <= s_fsel;
      if (fsel_fall || osc_cnt >= osc_last)                              // [R3]
      begin
        osc_cnt         <= {`SD_OSC_W{1'b0}};
        osc_cycle_start <= 1'b1;
      end
      else
      begin
        osc_cnt         <= osc_cnt + ONE[`SD_OSC_W-1:0];
        osc_cycle_start <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating mode

  reg  [2:0] mode;
  reg  [2:0] next_mode;
  wire       run_request;

  // Strap at reference: either pin wakes its rail; otherwise the master pin
  assign run_request = s_strap_ref ? (s_lo_on || s_hi_on) : s_lo_on;     // [R6] [R7]

  always @*
  begin
    next_mode = mode;
    case (mode)
      MD_SHUT: if (s_pd_n) next_mode = run_request ? MD_RUN : MD_STBY;
      MD_STBY: if (!s_pd_n) next_mode = MD_SHUT;
               else if (run_request) next_mode = MD_RUN;
      MD_RUN:  if (!s_pd_n) next_mode = MD_SHUT;                         // [R5]
               else if (!run_request) next_mode = MD_STBY;               // [R19]
      default: next_mode = MD_SHUT;
    endcase
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode          <= MD_SHUT;
      mode_shutdown <= 1'b1;
      mode_standby  <= 1'b0;
    end
    else
    begin
      mode          <= next_mode;
      mode_shutdown <= (next_mode == MD_SHUT);
      mode_standby  <= (next_mode == MD_STBY);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timing-pin discharge and rail enables

  reg  [`SD_DISCH_W-1:0] disch_cnt;
  reg                    first_up;
  reg                    delay_done;
  wire                   enter_shut;
  wire                   first_en;

  assign enter_shut = (mode != MD_SHUT) && (next_mode == MD_SHUT);
  // First rail in master mode: strap high picks the 3.3V rail
  assign first_en   = (mode == MD_RUN);

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      disch_cnt  <= {`SD_DISCH_W{1'b0}};
      first_up   <= 1'b1;
      delay_done <= 1'b0;
    end
    else
    begin
      // Short pulse at first power-up and on each entry to shutdown
      if (first_up || enter_shut)                                        // [R10]
        disch_cnt <= DISCH_LOAD[`SD_DISCH_W-1:0];
      else if (disch_cnt != {`SD_DISCH_W{1'b0}})
        disch_cnt <= disch_cnt - ONE[`SD_DISCH_W-1:0];
      first_up <= 1'b0;
      // Latch the threshold so a noisy ramp cannot drop the second rail
      if (mode != MD_RUN)
        delay_done <= 1'b0;
      else if (s_hi_on)
        delay_done <= 1'b1;                                              // [R9]
    end
  end

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      timing_discharge  <= 1'b1;
      low_rail_enabled  <= 1'b0;
      high_rail_enabled <= 1'b0;
    end
    else
    begin
      timing_discharge <= (mode == MD_STBY) || first_up || enter_shut
                          || (disch_cnt != {`SD_DISCH_W{1'b0}});         // [R10]
      if (mode != MD_RUN)
      begin
        low_rail_enabled  <= 1'b0;                                       // [R19] [R5]
        high_rail_enabled <= 1'b0;
      end
      else if (s_strap_ref)
      begin
        low_rail_enabled  <= s_lo_on;                                    // [R6]
        high_rail_enabled <= s_hi_on;                                    // [R6]
      end
      else if (s_strap_vl)
      begin
        low_rail_enabled  <= first_en;                                   // [R8]
        high_rail_enabled <= first_en && delay_done;                     // [R9]
      end
      else
      begin
        high_rail_enabled <= first_en;                                   // [R8]
        low_rail_enabled  <= first_en && delay_done;                     // [R9]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power-good timer

  reg  [`SD_PGOOD_W-1:0] pg_cnt;
  wire                   rails_good;

  // Reference strap ignores the 5V rail entirely
  assign rails_good = s_strap_ref ? s_lo_reg : (s_lo_reg && s_hi_reg);   // [R11] [R13]

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pg_cnt     <= {`SD_PGOOD_W{1'b0}};
      power_good <= 1'b0;
    end
    else if (mode != MD_RUN)
    begin
      pg_cnt     <= {`SD_PGOOD_W{1'b0}};                                 // [R21]
      power_good <= 1'b0;                                                // [R21]
    end
    else if (!power_good && rails_good && osc_cycle_start)
    begin
      if (pg_cnt == PGOOD_LAST[`SD_PGOOD_W-1:0])
        power_good <= 1'b1;                                              // [R12]
      pg_cnt <= pg_cnt + ONE[`SD_PGOOD_W-1:0];                           // [R12]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bootstrap switchover

  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bypass_switch_on           <= 1'b0;
      internal_rail_regulator_on <= 1'b0;
    end
    else
    begin
      // Both change on the same edge so the rail is never doubly fed
      bypass_switch_on           <= s_boot && (mode != MD_SHUT);         // [R17]
      internal_rail_regulator_on <= !s_boot && (mode != MD_SHUT);        // [R17] [R5]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Switch drivers

  sd_rail_drive u_low_rail (
    .ref_clk         (ref_clk),
    .arst_n          (arst_n),
    .enable          (low_rail_enabled),
    .cycle_start     (osc_cycle_start),
    .force_pwm       (s_force),
    .light_load      (pin_sync[`SD_IN_LO_LIGHT]),
    .pwm_trip        (pin_sync[`SD_IN_LO_TRIP]),
    .cur_limit       (pin_sync[`SD_IN_LO_LIM]),
    .zero_cross      (pin_sync[`SD_IN_LO_ZERO]),
    .high_side_drive (low_high_side_drive),
    .low_side_drive  (low_low_side_drive),
    .idle_skip       (low_idle_active)
  );

  sd_rail_drive u_high_rail (
    .ref_clk         (ref_clk),
    .arst_n          (arst_n),
    .enable          (high_rail_enabled),
    .cycle_start     (osc_cycle_start),
    .force_pwm       (s_force),
    .light_load      (pin_sync[`SD_IN_HI_LIGHT]),
    .pwm_trip        (pin_sync[`SD_IN_HI_TRIP]),
    .cur_limit       (pin_sync[`SD_IN_HI_LIM]),
    .zero_cross      (pin_sync[`SD_IN_HI_ZERO]),
    .high_side_drive (high_high_side_drive),
    .low_side_drive  (high_low_side_drive),
    .idle_skip       (high_idle_active)
  );

endmodule

// ===== tb/sd_seq_props.sv
`timescale 1ns/1ns
module sd_seq_props (
  // Clock and reset
  input  wire ref_clk,
  input  wire arst_n,
  // Pins
  input  wire power_down_n,
  input  wire force_pwm,
  input  wire low_cur_limit,
  input  wire high_rail_sense_low_above,
  // Outputs
  input  wire low_high_side_drive,
  input  wire low_low_side_drive,
  input  wire bypass_switch_on,
  input  wire internal_rail_regulator_on,
  input  wire timing_discharge,
  input  wire power_good,
  input  wire mode_shutdown,
  input  wire mode_standby,
  input  wire osc_cycle_start,
  input  wire low_idle_active
);
  localparam int PG_CYC = 32000;
  reg [15:0] starts;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////
  // Starts seen since leaving shutdown or standby
  always @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      starts <= 16'h0000;
    else if (mode_shutdown || mode_standby)
      starts <= 16'h0000;
    else if (osc_cycle_start && starts != 16'hFFFF)
      starts <= starts + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////
  a_no_overlap: assert property (!(low_high_side_drive && low_low_side_drive))
    else $error("both drives on together");
  a_dead_gap: assert property ($fell(low_high_side_drive) |-> !low_low_side_drive [*5])
    else $error("low drive on inside dead time");
  a_shutdown_all: assert property (!power_down_n [*5] |-> mode_shutdown && !power_good)
    else $error("power down did not force shutdown");
  a_limit_drop: assert property (low_cur_limit [*4] |-> !low_high_side_drive)
    else $error("high drive on during current limit");
  a_boot_switch: assert property ((!mode_shutdown && $stable(high_rail_sense_low_above)) [*4]
    |-> bypass_switch_on == high_rail_sense_low_above && internal_rail_regulator_on != bypass_switch_on)
    else $error("bypass and regulator out of step");
  a_standby_disch: assert property (mode_standby [*2] |-> timing_discharge)
    else $error("no discharge in standby");
  a_pgood_clear: assert property ((mode_shutdown || mode_standby) [*2] |-> !power_good)
    else $error("power good high outside run");
  a_pgood_count: assert property ($rose(power_good) |-> starts >= PG_CYC)
    else $error("power good before timeout");
  a_force_idle: assert property (force_pwm [*4] |-> !low_idle_active)
    else $error("idle active under forced pwm");
endmodule

bind sd_sequencer sd_seq_props sd_seq_props_inst (
  .ref_clk(ref_clk), .arst_n(arst_n), .power_down_n(power_down_n), .force_pwm(force_pwm),
  .low_cur_limit(low_cur_limit), .high_rail_sense_low_above(high_rail_sense_low_above),
  .low_high_side_drive(low_high_side_drive), .low_low_side_drive(low_low_side_drive),
  .bypass_switch_on(bypass_switch_on), .internal_rail_regulator_on(internal_rail_regulator_on),
  .timing_discharge(timing_discharge), .power_good(power_good), .mode_shutdown(mode_shutdown),
  .mode_standby(mode_standby), .osc_cycle_start(osc_cycle_start), .low_idle_active(low_idle_active)
);

// ===== tb/sd_sys_partner.sv
`timescale 1ns/1ns
module sd_sys_partner (
  // Clock
  input  wire ref_clk,
  // Commands
  input  wire ext_clk_en,
  input  wire fast,
  input  wire sel_level,
  input  wire use_cap,
  input  wire on_level,
  // Device side
  input  wire timing_discharge,
  output reg  freq_select,
  output wire high_rail_on_or_delay
);
  parameter CAP_CYC = 400;
  reg [8:0]  half = 9'h000;
  reg [15:0] cap = 16'h0000;

  initial freq_select = 1'h0;

  always @(posedge ref_clk)
  begin
    if (!ext_clk_en)
    begin
      freq_select <= sel_level;
      half <= 9'h000;
    end
    else if (half == 9'h000)
    begin
      freq_select <= !freq_select;
      half <= fast ? 9'h000 : 9'h063; // Slow keeps the capture range; fast only shortens the timeout run
    end
    else
      half <= half - 9'h001;
  end

  // Capacitor ramps once the pull-down lets go
  always @(posedge ref_clk)
  begin
    if (timing_discharge)
      cap <= 16'h0000;
    else if (cap != 16'hFFFF)
      cap <= cap + 16'h0001;
  end
  assign high_rail_on_or_delay = use_cap ? (cap >= CAP_CYC) : on_level;
endmodule

// ===== tb/sd_sequencer_bench.sv
`timescale 1ns/1ns
module sd_sequencer_bench;
  reg  ref_clk = 1'h0, arst_n = 1'h0, power_down_n = 1'h0, sel = 1'h0, ext = 1'h0, fast = 1'h0;
  reg  force_pwm = 1'h1, lo_on = 1'h0, hi_on = 1'h0, use_cap = 1'h0, s_ref = 1'h1, s_vl = 1'h0;
  reg  lo_reg = 1'h0, hi_reg = 1'h0, above = 1'h0, lim = 1'h0, zc = 1'h0, trip = 1'h0, light = 1'h0;
  wire fsel, hi_pin, lhs, lls, bypass, lin_reg, disch, lo_en, hi_en, pg, m_sd, m_sb, osc, lo_idle;
  wire hhs, hls, hi_idle;
  int  failures = 0, check_count = 0, n;
  // Rows: strap ref, strap rail, low on, high on | standby, discharge, low en, high en
  logic [7:0] rows [6] = '{8'h8C, 8'hA2, 8'h91, 8'hB3, 8'h4C, 8'h0C};

  initial forever #5 ref_clk = !ref_clk;

  sd_sys_partner sd_sys_partner_inst (.ref_clk(ref_clk), .ext_clk_en(ext), .fast(fast), .sel_level(sel),
    .use_cap(use_cap), .on_level(hi_on), .timing_discharge(disch), .freq_select(fsel),
    .high_rail_on_or_delay(hi_pin));

  sd_sequencer sd_sequencer_inst (.ref_clk(ref_clk), .arst_n(arst_n), .power_down_n(power_down_n),
    .freq_select(fsel), .force_pwm(force_pwm), .low_rail_on(lo_on), .high_rail_on_or_delay(hi_pin),
    .order_select_strap_ref(s_ref), .order_select_strap_internal_rail(s_vl), .low_rail_in_reg(lo_reg),
    .high_rail_in_reg(hi_reg), .high_rail_sense_low_above(above), .low_cur_limit(lim),
    .low_zero_cross(zc), .low_pwm_trip(trip), .low_light_load(light), .high_cur_limit(lim),
    .high_zero_cross(zc), .high_pwm_trip(trip), .high_light_load(light), .low_high_side_drive(lhs),
    .low_low_side_drive(lls), .high_high_side_drive(hhs), .high_low_side_drive(hls), .bypass_switch_on(bypass),
    .internal_rail_regulator_on(lin_reg), .timing_discharge(disch), .low_rail_enabled(lo_en),
    .high_rail_enabled(hi_en), .power_good(pg), .mode_shutdown(m_sd), .mode_standby(m_sb),
    .osc_cycle_start(osc), .low_idle_active(lo_idle), .high_idle_active(hi_idle));

  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
  begin
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask

  task automatic ticks(input int k);
  begin
    repeat (k) @(negedge ref_clk);
  end
  endtask

  // Cycles until the next start pulse, bounded
  task automatic gap(output int k);
  begin
    k = 0;
    do
    begin
      @(negedge ref_clk);
      k++;
    end
    while (!osc && k < 1000);
  end
  endtask

  task automatic master_seq(input logic vl);
  begin
    @(posedge ref_clk);
    {s_ref, s_vl, lo_on, use_cap} <= {1'h0, vl, 1'h0, 1'h1};
    ticks(20);
    @(posedge ref_clk);
    lo_on <= 1'h1;
    ticks(10);
    chk("first rail", {2'h0, vl, !vl}, {2'h0, lo_en, hi_en});
    ticks(300);
    chk("second held", {2'h0, vl, !vl}, {2'h0, lo_en, hi_en});
    ticks(200);
    chk("second on", 4'h3, {2'h0, lo_en, hi_en});
  end
  endtask

  task close_out;
  begin
    $display("Checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'h1;
    lo_on <= 1'h1;
    ticks(10);
    chk("shutdown", 4'h8, {m_sd, pg, lo_en, hi_en});
    @(posedge ref_clk);
    power_down_n <= 1'h1;
    ticks(120);
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      {s_ref, s_vl, lo_on, hi_on} <= rows[i][7:4];
      use_cap <= !rows[i][7];
      ticks(8);
      chk("mode row", rows[i][3:0], {m_sb, disch, lo_en, hi_en});
    end
    master_seq(1'h1);
    master_seq(1'h0);
    // Oscillator rates, then a sync fall at an arbitrary phase
    @(posedge ref_clk);
    {s_ref, use_cap, lo_on, hi_on} <= 4'h8;
    ticks(10);
    gap(n);
    gap(n);
    chk("slow period", 4'h1, 4'(n == 300));
    @(posedge ref_clk);
    sel <= 1'h1;
    gap(n);
    gap(n);
    chk("fast period", 4'h1, 4'(n == 200));
    @(posedge ref_clk);
    ext <= 1'h1;
    wait (fsel);
    @(negedge fsel);
    gap(n);
    chk("sync restart", 4'h1, 4'(n <= 5));
    // Drive timing
    @(posedge ref_clk);
    lo_on <= 1'h1;
    ticks(10);
    n = 0;
    while (!lhs && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("high on", 4'h4, {1'h0, lhs, hhs, hls});
    @(posedge ref_clk);
    trip <= 1'h1;
    ticks(4);
    n = 0;
    while (!lls && n < 20)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("dead time", 4'h1, 4'(n >= 5 && n <= 8 && !lhs));
    @(posedge ref_clk);
    trip <= 1'h0;
    ticks(40);
    chk("low held", 4'h1, 4'(lls));
    @(posedge ref_clk);
    {force_pwm, zc} <= 2'h1;
    ticks(6);
    chk("zero cross", 4'h0, 4'(lls));
    // Limit must cut a pulse that is already on
    @(posedge ref_clk);
    zc <= 1'h0;
    n = 0;
    while (!lhs && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    lim <= 1'h1;
    ticks(4);
    n = 0;
    repeat (400)
    begin
      @(negedge ref_clk);
      n += lhs;
    end
    chk("limit", 4'h0, 4'(n));
    @(posedge ref_clk);
    {lim, light} <= 2'h1;
    ticks(5);
    chk("idle", 4'h3, {2'h0, lo_idle, hi_idle});
    @(posedge ref_clk);
    {force_pwm, above} <= 2'h3;
    ticks(6);
    chk("force and boot", 4'h4, {lo_idle, bypass, lin_reg, hi_idle});
    // Power-good: only the low rail counts with the strap at reference
    @(posedge ref_clk);
    {ext, fast, sel, hi_reg} <= 4'hD;
    ticks(2000);
    chk("pg no reg", 4'h0, 4'(pg));
    @(posedge ref_clk);
    {lo_reg, hi_reg} <= 2'h2;
    n = 0;
    while (n < 31990)
    begin
      @(negedge ref_clk);
      n += osc;
    end
    chk("pg early", 4'h0, 4'(pg));
    while (n < 32010)
    begin
      @(negedge ref_clk);
      n += osc;
    end
    chk("pg late", 4'h1, 4'(pg));
    @(posedge ref_clk);
    power_down_n <= 1'h0;
    ticks(8);
    chk("pd clears", 4'h8, {m_sd, pg, lo_en, hi_en});
    @(posedge ref_clk);
    power_down_n <= 1'h1;
    ticks(50);
    chk("pg restarts", 4'h0, 4'(pg));
    close_out;
  end

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    failures++;
    close_out;
  end
endmodule
